// >>> piso_pkg.sv
// constants shared by the parallel-in serial-out shifter and its snapshot fifo
package piso_pkg;
  localparam int STAGES = 8;
  localparam int SNAP_DEPTH = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [STAGES-1:0] STAGE_RESET = 8'h00;
  localparam logic MODE_LOAD = 1'b0;
  localparam logic MODE_SHIFT = 1'b1;
endpackage

// >>> piso_fifo.sv
// snapshot fifo with valid and ready on both sides and a registered output
`timescale 1ns/10ps
module piso_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_check
    $error("piso_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop;

  always_comb
  begin
    // full is honest: the source stalls until the drain makes room
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    push = in_valid && in_ready;
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rd_q] : od_q;
    out_valid = ov_q;
    out_data = od_q;
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end
endmodule // piso_fifo

// >>> piso_shifter.sv
// eight-stage parallel-in serial-out shifter with snapshot fifo
`timescale 1ns/10ps
module piso_shifter #(
  parameter int STAGES = piso_pkg::STAGES,
  parameter int SNAP_DEPTH = piso_pkg::SNAP_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins from the controller
  input wire logic shift_clock,
  input wire logic clock_gate_block,
  input wire logic shift_mode,
  input wire logic serial_in,
  input wire logic [STAGES-1:0] parallel_in,
  // serial outputs
  output logic last_stage_out,
  output logic last_stage_out_inverted,
  output logic first_stage_value,
  // snapshot stream
  output logic snap_valid,
  input wire logic snap_ready,
  output logic [STAGES-1:0] snap_data,
  // status
  output logic overrun
);
  localparam int PINS = STAGES + 4;
  localparam int SYNC = piso_pkg::SYNC_STAGES;

  // the reset image is a package constant of fixed width
  if (STAGES != piso_pkg::STAGES)
  begin : g_check
    $error("piso_shifter: stage count is fixed by the reset constant");
  end

  // a chain needs at least one stage behind the first
  if (STAGES < 2)
  begin : g_check_len
    $error("piso_shifter: at least two stages are needed");
  end

  // one flop alone would let a metastable pin reach the logic
  if (SYNC < 2)
  begin : g_check_sync
    $error("piso_shifter: the pin synchroniser needs at least two flops");
  end

  // pin synchroniser: every pin is asynchronous to clk
  logic [PINS-1:0] pin_bus;
  logic [PINS-1:0] sync_q [SYNC];
  logic [PINS-1:0] sync_d [SYNC];

  always_comb
  begin
    pin_bus = {shift_clock, clock_gate_block, shift_mode, serial_in, parallel_in};
    sync_d[0] = pin_bus;
    for (int i = 1; i < SYNC; i++)
    begin
      sync_d[i] = sync_q[i-1];
    end
  end

  // no reset: a cleared chain would show a false low on a pin that is already high,
  // and the edge detector would then take its rise for a clock edge
  always_ff @(posedge clk)
  begin
    sync_q <= sync_d;
  end

  // only the last flop of the chain is read
  logic s_clk, s_inh, s_mode, s_ser;
  logic [STAGES-1:0] s_par;

  always_comb
  begin
    {s_clk, s_inh, s_mode, s_ser, s_par} = sync_q[SYNC-1];
  end

  // effective clock
  // in shift mode either input held high freezes the chain, a rise of the or is the active edge
  logic gated, active_edge;
  logic gate_prev_q, gate_prev_d;

  always_comb
  begin
    gated = s_clk | s_inh;
    active_edge = gated && !gate_prev_q;
    gate_prev_d = gated;
  end

  // resets high: a clock already high at release is not an edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gate_prev_q <= 1'h1;
    end
    else
    begin
      gate_prev_q <= gate_prev_d;
    end
  end

  // stage register and snapshot handshake
  logic [STAGES-1:0] stage_q, stage_d;
  logic [STAGES-1:0] shift_image;
  logic want, stall, fifo_ready;

  always_comb
  begin
    shift_image[0] = s_ser;
    for (int k = 1; k < STAGES; k++)
    begin
      shift_image[k] = stage_q[k-1];
    end
  end

  always_comb
  begin
    stage_d = stage_q;
    want = 1'h0;
    if (s_mode == piso_pkg::MODE_LOAD)
    begin
      // parallel load
      // level load: the clock is don't-care, and only a change is worth an image
      if (s_par != stage_q)
      begin
        stage_d = s_par;
        want = 1'h1;
      end
    end
    else if (active_edge)
    begin
      stage_d = shift_image;
      want = 1'h1;
    end
    // gated chain
    // a full fifo stalls the update; the pin edge is lost, so it is flagged
    stall = want && !fifo_ready;
    if (stall)
    begin
      stage_d = stage_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage_q <= piso_pkg::STAGE_RESET;
    end
    else
    begin
      stage_q <= stage_d;
    end
  end

  // inverse output
  // a flop of its own, so this output too comes straight from a register
  logic inv_q, inv_d;

  always_comb
  begin
    inv_d = ~stage_d[STAGES-1];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inv_q <= ~piso_pkg::STAGE_RESET[STAGES-1];
    end
    else
    begin
      inv_q <= inv_d;
    end
  end

  // sticky: with no register bus only reset clears it
  logic ovr_q, ovr_d;

  always_comb
  begin
    ovr_d = ovr_q | stall;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ovr_q <= 1'h0;
    end
    else
    begin
      ovr_q <= ovr_d;
    end
  end

  // each accepted update pushes the new register image
  piso_fifo #(
    .WIDTH(STAGES),
    .DEPTH(SNAP_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(want),
    .in_ready(fifo_ready),
    .in_data(stage_d),
    .out_valid(snap_valid),
    .out_ready(snap_ready),
    .out_data(snap_data)
  );

  always_comb
  begin
    last_stage_out = stage_q[STAGES-1];
    last_stage_out_inverted = inv_q;
    first_stage_value = stage_q[0];
    overrun = ovr_q;
  end
endmodule // piso_shifter

// >>> piso_checker.sv
// port assertions for the shifter
`timescale 1ns/10ps
module piso_checker #(
  parameter int STAGES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic shift_clock,
  input wire logic clock_gate_block,
  input wire logic shift_mode,
  input wire logic serial_in,
  input wire logic [STAGES-1:0] parallel_in,
  input wire logic last_stage_out,
  input wire logic last_stage_out_inverted,
  input wire logic first_stage_value,
  input wire logic overrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_inv_pair: assert property (last_stage_out_inverted == !last_stage_out)
    else $error("inverse output wrong");
  // 3 clk pipeline, sampled one edge later
  chk_serial_entry: assert property (shift_mode && !clock_gate_block && !overrun &&
    $rose(shift_clock) |-> ##4 (overrun || first_stage_value == $past(serial_in, 4)))
    else $error("serial bit not in first stage");
  chk_hold_high: assert property (
    (shift_mode && (shift_clock || clock_gate_block))[*6] |-> $stable(first_stage_value))
    else $error("moved while clock held");
  chk_idle_keep: assert property (
    (shift_mode && !shift_clock && !clock_gate_block)[*6] |-> $stable(last_stage_out))
    else $error("moved without clock");
  chk_load_par: assert property (
    (!shift_mode && !overrun && $stable(parallel_in))[*5] |->
    last_stage_out == parallel_in[STAGES-1] && first_stage_value == parallel_in[0])
    else $error("load not shown");
endmodule // piso_checker
bind piso_shifter piso_checker #(.STAGES(STAGES)) u_chk (.*);

// >>> piso_ctrl_model.sv
// controller model driving the pins and draining snapshots
`timescale 1ns/10ps
module piso_ctrl_model (
  // clock
  input wire logic clk,
  // pins
  output logic shift_clock,
  output logic clock_gate_block,
  output logic shift_mode,
  output logic serial_in,
  output logic [7:0] parallel_in,
  // snapshot stream
  input wire logic snap_valid,
  output logic snap_ready,
  input wire logic [7:0] snap_data
);
  logic drain_en = 1'b1;
  logic [7:0] last_word = 8'h00;
  int words = 0;
  initial {shift_clock, clock_gate_block, shift_mode, serial_in, parallel_in, snap_ready} = '0;
  // a stalled drain lets the fifo fill
  always @(posedge clk)
  begin
    snap_ready <= drain_en;
    if (snap_valid && snap_ready)
    begin
      last_word <= snap_data;
      words <= words + 1;
    end
  end
  task automatic pulse(input logic b);
    serial_in <= b;
    repeat (3) @(posedge clk);
    shift_clock <= 1'b1;
    repeat (3) @(posedge clk);
    shift_clock <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic hold_clock();
    shift_clock <= 1'b1;
    repeat (3) @(posedge clk);
    clock_gate_block <= 1'b1;
    repeat (3) @(posedge clk);
    shift_clock <= 1'b0;
    repeat (3) @(posedge clk);
    clock_gate_block <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic load(input logic [7:0] v);
    shift_mode <= 1'b0;
    parallel_in <= v;
    repeat (7) @(posedge clk);
    shift_mode <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule // piso_ctrl_model

// >>> tb_top.sv
// testbench for the shifter
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sc, cg, sm, si, lo, li, fv, sv, sr, ov;
  logic [7:0] pi, sd;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  always #50 clk = ~clk;
  piso_ctrl_model m (.clk(clk), .shift_clock(sc), .clock_gate_block(cg), .shift_mode(sm),
    .serial_in(si), .parallel_in(pi), .snap_valid(sv), .snap_ready(sr), .snap_data(sd));
  piso_shifter dut (.clk(clk), .reset(reset), .shift_clock(sc), .clock_gate_block(cg),
    .shift_mode(sm), .serial_in(si), .parallel_in(pi), .last_stage_out(lo),
    .last_stage_out_inverted(li), .first_stage_value(fv), .snap_valid(sv),
    .snap_ready(sr), .snap_data(sd), .overrun(ov));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic test_load_shift();
    m.load(8'ha5);
    `CHK("last", 1'b1, lo)
    `CHK("snap", 8'ha5, m.last_word)
    for (int k = 0; k < 8; k++)
    begin
      m.pulse(k[0]);
      `CHK("first", k[0], fv)
      `CHK("last", (k < 7) ? 8'ha5 >> (6 - k) & 1 : 0, {7'h00, lo})
    end
    `CHK("shifted image", 8'h55, m.last_word)
    $display("load and shift done");
  endtask
  task automatic test_hold();
    m.parallel_in <= 8'h3c;
    m.hold_clock();
    `CHK("held", 2'h3, {fv, lo})
    `CHK("inverse", 1'h0, li)
    `CHK("one shift", 8'hab, m.last_word)
    $display("hold done");
  endtask
  task automatic test_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("reset image", 4'h4, {lo, li, fv, ov})
    `CHK("reset stream", 9'h000, {sv, sd})
    $display("reset done");
  endtask
  task automatic test_fill();
    m.drain_en <= 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      m.load(8'h10 + i[7:0]);
      `CHK("overrun", i == 17, ov)
    end
    n = m.words;
    m.drain_en <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("drained", 17, m.words - n)
    `CHK("tail", 8'h20, m.last_word)
    $display("fill done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    test_load_shift();
    test_hold();
    test_fill();
    test_reset();
    close_out();
  end
  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule // tb_top
